// ### bench/fmc_match_capture_tb_top.sv
// Purpose: Self-checking bench for the timer match and capture block
// Assumes: APB master that waits for pready, counter stopped while capturing
// Notes: Capture checks freeze the count so pin latency cannot skew values
`default_nettype none

module fmc_match_capture_tb_top
  import fmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic gpin = 1'b0;
  logic tpin = 1'b0;
  logic [FMC_CNT_W-1:0] count_value;
  logic [FMC_ST_W-1:0] irq_st;
  int err_total = 0;
  int n_checks = 0;
  int k;
  logic [31:0] rd;
  logic er;
  logic [31:0] v;
  logic [31:0] cap_exp [2] = '{32'h0000_0000, 32'h0000_0000};
  logic [2:0] modes [3] = '{3'b101, 3'b010, 3'b011};
  logic [31:0] rst_addr [7] = '{FMC_ADDR_MCTRL, FMC_ADDR_CMP_A, FMC_ADDR_CMP_B,
    FMC_ADDR_CMP_C, FMC_ADDR_CCR, FMC_ADDR_CAP_A, FMC_ADDR_CAP_B};

  fmc_match_capture u_fmc_match_capture (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .general_capture_input(gpin),
    .tick_capture_input(tpin),
    .count_value(count_value),
    .timer_irq_status(irq_st)
  );

  initial begin
    forever #4 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", {31'h0, pready}, 32'h0000_0001);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  task automatic wait_count(input logic [31:0] c);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (count_value !== c && n < 200);
    chk("count reach", count_value, c);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdc("reset value", rst_addr[i], 32'h0000_0000);
      chk("mapped error", {31'h0, er}, 32'h0000_0000);
    end
    apb(1'b0, 32'h4003_8024, 32'h0000_0000);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    wr(FMC_ADDR_CAP_A, 32'hFFFF_FFFF);
    wr(FMC_ADDR_CAP_B, 32'hFFFF_FFFF);
    rdc("capture a ro", FMC_ADDR_CAP_A, 32'h0000_0000);
    rdc("capture b ro", FMC_ADDR_CAP_B, 32'h0000_0000);
    // Write all compares first so an aliased address shows up
    for (int i = 0; i < 3; i++) wr(FMC_ADDR_CMP_A + 32'(4 * i), 32'hA5C3_0000 | 32'(i));
    for (int i = 0; i < 3; i++) begin
      rdc("compare rw", FMC_ADDR_CMP_A + 32'(4 * i), 32'hA5C3_0000 | 32'(i));
    end
    // Last read left nonzero data, so a stale word would show here
    apb(1'b0, 32'h4003_8024, 32'h0000_0000);
    chk("unmapped data", rd, 32'h0000_0000);
    wr(FMC_ADDR_MCTRL, 32'hFFFF_FFFF);
    rdc("match ctrl", FMC_ADDR_MCTRL, 32'h0000_01FF);
    wr(FMC_ADDR_CCR, 32'hFFFF_FFFF);
    rdc("capture ctrl", FMC_ADDR_CCR, 32'h0000_003F);
    wr(FMC_ADDR_CCR, 32'h0000_0000);
    wr(FMC_ADDR_PLIMIT, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(FMC_ADDR_CTRL, 32'h0000_0002);
      wr(FMC_ADDR_CTRL, 32'h0000_0000);
      wr(FMC_ADDR_STATUS, 32'h0000_003F);
      wr(FMC_ADDR_CMP_A + 32'(4 * i), 32'h0000_0006);
      wr(FMC_ADDR_MCTRL, 32'h0000_0003 << (3 * i));
      wr(FMC_ADDR_CTRL, 32'h0000_0001);
      wait_count(32'h0000_0006);
      @(posedge pclk);
      chk("count after clear", count_value, 32'h0000_0000);
      chk("match status", {26'h0, irq_st}, 32'h0000_0001 << i);
      wr(FMC_ADDR_CTRL, 32'h0000_0000);
      wr(FMC_ADDR_COUNT, 32'h0000_0064);
      repeat (3) @(posedge pclk);
      chk("stopped count", count_value, 32'h0000_0064);
      wr(FMC_ADDR_STATUS, 32'h0000_0000);
      rdc("status kept", FMC_ADDR_STATUS, 32'h0000_0001 << i);
      wr(FMC_ADDR_STATUS, 32'h0000_0001 << i);
      rdc("status cleared", FMC_ADDR_STATUS, 32'h0000_0000);
    end
    // Prescale of 2 keeps the halt ahead of the next count tick
    wr(FMC_ADDR_CTRL, 32'h0000_0002);
    wr(FMC_ADDR_CTRL, 32'h0000_0000);
    wr(FMC_ADDR_CMP_A, 32'h0000_0006);
    wr(FMC_ADDR_MCTRL, 32'h0000_0004);
    wr(FMC_ADDR_PLIMIT, 32'h0000_0002);
    wr(FMC_ADDR_CTRL, 32'h0000_0001);
    wait_count(32'h0000_0005);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (count_value !== 32'h0000_0006 && k < 20);
    chk("prescale period", 32'(k), 32'h0000_0003);
    repeat (8) @(posedge pclk);
    chk("halted count", count_value, 32'h0000_0006);
    chk("gated status", {26'h0, irq_st}, 32'h0000_0000);
    rdc("run cleared", FMC_ADDR_CTRL, 32'h0000_0000);
    wr(FMC_ADDR_PCOUNT, 32'h0000_0001);
    rdc("prescale count", FMC_ADDR_PCOUNT, 32'h0000_0001);
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 3; m++) begin
        wr(FMC_ADDR_CCR, 32'(modes[m]) << (3 * ch));
        for (int e = 0; e < 2; e++) begin
          v = 32'h1000_0000 + 32'(ch * 16 + m * 4 + e);
          wr(FMC_ADDR_COUNT, v);
          wr(FMC_ADDR_STATUS, 32'h0000_003F);
          @(posedge pclk);
          if (ch == 0) gpin <= (e == 0);
          else tpin <= (e == 0);
          repeat (8) @(posedge pclk);
          if (modes[m][e]) cap_exp[ch] = v;
          rdc("captured", FMC_ADDR_CAP_A + 32'(4 * ch), cap_exp[ch]);
          rdc("capture status", FMC_ADDR_STATUS, (modes[m][e] && modes[m][2]) ?
            32'h0000_0001 << (4 + ch) : 32'h0000_0000);
        end
      end
    end
    complete_run();
  end
endmodule

`default_nettype wire

// ### hw/fmc_capture_chan.sv
// Purpose: One capture channel, synchroniser, edge detect and count latch
// Assumes: Capture pin is asynchronous to pclk
// Notes: Latch takes the count seen in the cycle the edge is detected
`default_nettype none

module fmc_capture_chan
  import fmc_pkg::*;
#(
  parameter int unsigned W = FMC_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic capture_pin,
  input wire logic rise_enable,
  input wire logic fall_enable,
  input wire logic [W-1:0] count_value,
  output logic capture_pulse,
  output logic [W-1:0] latched_count
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic [W-1:0] latched_count_ff;

  // Meta stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= capture_pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Both enables together give capture on either edge
  assign capture_pulse = (rise_enable && sync_ff && !prev_ff) ||
                         (fall_enable && !sync_ff && prev_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_count_ff <= '0;
    end else if (capture_pulse) begin
      latched_count_ff <= count_value;
    end
  end

  assign latched_count = latched_count_ff;

endmodule

`default_nettype wire

// ### hw/fmc_match_capture.sv
// Purpose: Match and capture section of the fast timer, with its counter core
// Assumes: APB slave, pclk is the peripheral clock, single clock domain
// Notes: Each transfer has one wait state so bus outputs come from flops
//
// Function
// - Match control bit 0 gates compare A status
// - Bit 1 clears counter on compare A
// - Bit 2 halts counter on compare A
// - Match control bit 3 gates compare B status
// - Bits 4-8 give B and C actions
// - Compare registers 32-bit RW, reset zero, no side-effects
// - Clear on match at end of matched period
// - Match status rises one clock after reaching
// - Halt clears run enable one clock later
// - Capture bit 0: rising edge loads capture A
// - Capture bit 1: falling edge loads capture A
// - Capture bit 2: capture A sets status
// - Capture bit 3: rising tick loads capture B
// - Capture bit 4: falling tick loads capture B
// - Capture bit 5: capture B sets status
// - Both edge enables together capture either edge
// - Capture control bits 31:6 ignore writes
// - Capture A read-only, reset zero, last count
// - Capture B read-only, reset zero, last count
// - Counter advances every prescale limit plus one
// - Status write one clears, zero keeps
// - Counter runs only while run enable set
//
// The APB register port is this design's own decision.
`default_nettype none

module fmc_match_capture
  import fmc_pkg::*;
#(
  parameter int unsigned PRESCALE_W = FMC_PRESCALE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic general_capture_input,
  input wire logic tick_capture_input,
  output logic [FMC_CNT_W-1:0] count_value,
  output logic [FMC_ST_W-1:0] timer_irq_status
);

  if (PRESCALE_W < 1 || PRESCALE_W > 32) begin : g_bad_width
    $error("PRESCALE_W must lie between 1 and 32");
  end

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [FMC_CTRL_W-1:0] timer_control_ff;
  logic [PRESCALE_W-1:0] prescale_limit_ff;
  logic [PRESCALE_W-1:0] pcount_ff;
  logic [FMC_CNT_W-1:0] count_ff;
  logic [FMC_MCTRL_W-1:0] match_action_control_ff;
  logic [FMC_CNT_W-1:0] compare_ff [FMC_NUM_CMP];
  logic [FMC_CCR_W-1:0] capture_edge_control_ff;
  logic [FMC_ST_W-1:0] timer_irq_status_ff;
  logic [FMC_ST_W-1:0] nxt_status;
  logic [FMC_CNT_W-1:0] captured_count_a;
  logic [FMC_CNT_W-1:0] captured_count_b;
  logic cap_a_pulse;
  logic cap_b_pulse;
  logic [FMC_NUM_CMP-1:0] cmp_hit;
  logic [FMC_NUM_CMP-1:0] irq_en;
  logic [FMC_NUM_CMP-1:0] clr_en;
  logic [FMC_NUM_CMP-1:0] halt_en;
  logic any_clear;
  logic any_halt;
  logic tick;
  logic acc_first;
  logic wr_take;
  logic [31:0] rd_word;
  logic addr_ok;

  // Bus handshake, one wait state per access
  assign acc_first = psel && penable && !pready_ff;
  assign wr_take = psel && penable && pready_ff && pwrite && !pslverr_ff;

  always_comb begin
    rd_word = FMC_RST_WORD;
    addr_ok = 1'b1;
    if (paddr == FMC_ADDR_STATUS) begin
      rd_word = 32'(timer_irq_status_ff);
    end else if (paddr == FMC_ADDR_CTRL) begin
      rd_word = 32'(timer_control_ff);
    end else if (paddr == FMC_ADDR_COUNT) begin
      rd_word = count_ff;
    end else if (paddr == FMC_ADDR_PLIMIT) begin
      rd_word = 32'(prescale_limit_ff);
    end else if (paddr == FMC_ADDR_PCOUNT) begin
      rd_word = 32'(pcount_ff);
    end else if (paddr == FMC_ADDR_MCTRL) begin
      rd_word = 32'(match_action_control_ff);
    end else if (paddr == FMC_ADDR_CMP_A) begin
      rd_word = compare_ff[0];
    end else if (paddr == FMC_ADDR_CMP_B) begin
      rd_word = compare_ff[1];
    end else if (paddr == FMC_ADDR_CMP_C) begin
      rd_word = compare_ff[2];
    end else if (paddr == FMC_ADDR_CCR) begin
      rd_word = 32'(capture_edge_control_ff);
    end else if (paddr == FMC_ADDR_CAP_A) begin
      rd_word = captured_count_a;
    end else if (paddr == FMC_ADDR_CAP_B) begin
      rd_word = captured_count_b;
    end else begin
      addr_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= FMC_RST_WORD;
    end else begin
      pready_ff <= acc_first;
      pslverr_ff <= acc_first && !addr_ok;
      if (acc_first && !pwrite) begin
        prdata_ff <= rd_word;
      end
    end
  end

  // Match decode, one field group per compare register
  for (genvar i = 0; i < FMC_NUM_CMP; i++) begin : g_cmp
    assign cmp_hit[i] = (count_ff == compare_ff[i]);
    assign irq_en[i] = match_action_control_ff[i*FMC_MC_STRIDE+FMC_MC_IRQ];
    assign clr_en[i] = match_action_control_ff[i*FMC_MC_STRIDE+FMC_MC_CLR];
    assign halt_en[i] = match_action_control_ff[i*FMC_MC_STRIDE+FMC_MC_HALT];
  end

  assign any_clear = |(cmp_hit & clr_en);
  assign any_halt = |(cmp_hit & halt_en);

  // Control and configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_action_control_ff <= FMC_RST_WORD[FMC_MCTRL_W-1:0];
      capture_edge_control_ff <= FMC_RST_WORD[FMC_CCR_W-1:0];
      prescale_limit_ff <= FMC_RST_WORD[PRESCALE_W-1:0];
      for (int k = 0; k < FMC_NUM_CMP; k++) begin
        compare_ff[k] <= FMC_RST_WORD;
      end
    end else if (wr_take) begin
      if (paddr == FMC_ADDR_MCTRL) begin
        match_action_control_ff <= pwdata[FMC_MCTRL_W-1:0];
      end else if (paddr == FMC_ADDR_CCR) begin
        capture_edge_control_ff <= pwdata[FMC_CCR_W-1:0];
      end else if (paddr == FMC_ADDR_PLIMIT) begin
        prescale_limit_ff <= pwdata[PRESCALE_W-1:0];
      end else if (paddr == FMC_ADDR_CMP_A) begin
        compare_ff[0] <= pwdata;
      end else if (paddr == FMC_ADDR_CMP_B) begin
        compare_ff[1] <= pwdata;
      end else if (paddr == FMC_ADDR_CMP_C) begin
        compare_ff[2] <= pwdata;
      end
    end
  end

  // Run enable: a halting match beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_ff <= FMC_RST_WORD[FMC_CTRL_W-1:0];
    end else begin
      if (wr_take && paddr == FMC_ADDR_CTRL) begin
        timer_control_ff <= pwdata[FMC_CTRL_W-1:0];
      end
      if (any_halt) begin
        timer_control_ff[FMC_CTRL_RUN] <= 1'b0;
      end
    end
  end

  // Prescaler
  assign tick = timer_control_ff[FMC_CTRL_RUN] && !timer_control_ff[FMC_CTRL_CLR] &&
                (pcount_ff == prescale_limit_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcount_ff <= FMC_RST_WORD[PRESCALE_W-1:0];
    end else if (timer_control_ff[FMC_CTRL_CLR]) begin
      pcount_ff <= '0;
    end else if (wr_take && paddr == FMC_ADDR_PCOUNT) begin
      pcount_ff <= pwdata[PRESCALE_W-1:0];
    end else if (tick) begin
      pcount_ff <= '0;
    end else if (timer_control_ff[FMC_CTRL_RUN]) begin
      pcount_ff <= pcount_ff + 1'b1;
    end
  end

  // Counter clears at once on control bit 1, and on a match only at the tick that ends the matched period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= FMC_RST_WORD;
    end else if (timer_control_ff[FMC_CTRL_CLR]) begin
      count_ff <= '0;
    end else if (wr_take && paddr == FMC_ADDR_COUNT) begin
      count_ff <= pwdata;
    end else if (tick) begin
      count_ff <= any_clear ? '0 : count_ff + 1'b1;
    end
  end

  // Capture channels
  fmc_capture_chan #(
    .W(FMC_CNT_W)
  ) u_cap_a (
    .pclk(pclk),
    .presetn(presetn),
    .capture_pin(general_capture_input),
    .rise_enable(capture_edge_control_ff[FMC_CC_RISE]),
    .fall_enable(capture_edge_control_ff[FMC_CC_FALL]),
    .count_value(count_ff),
    .capture_pulse(cap_a_pulse),
    .latched_count(captured_count_a)
  );

  fmc_capture_chan #(
    .W(FMC_CNT_W)
  ) u_cap_b (
    .pclk(pclk),
    .presetn(presetn),
    .capture_pin(tick_capture_input),
    .rise_enable(capture_edge_control_ff[FMC_CC_STRIDE+FMC_CC_RISE]),
    .fall_enable(capture_edge_control_ff[FMC_CC_STRIDE+FMC_CC_FALL]),
    .count_value(count_ff),
    .capture_pulse(cap_b_pulse),
    .latched_count(captured_count_b)
  );

  // Sticky status; a new event wins over a clear in the same cycle
  always_comb begin
    nxt_status = timer_irq_status_ff;
    if (wr_take && paddr == FMC_ADDR_STATUS) begin
      nxt_status = nxt_status & ~pwdata[FMC_ST_W-1:0];
    end
    nxt_status[FMC_ST_MATCH +: FMC_NUM_CMP] =
      nxt_status[FMC_ST_MATCH +: FMC_NUM_CMP] | (cmp_hit & irq_en);
    if (cap_a_pulse && capture_edge_control_ff[FMC_CC_IRQ]) begin
      nxt_status[FMC_ST_CAP_A] = 1'b1;
    end
    if (cap_b_pulse && capture_edge_control_ff[FMC_CC_STRIDE+FMC_CC_IRQ]) begin
      nxt_status[FMC_ST_CAP_B] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_status_ff <= FMC_RST_WORD[FMC_ST_W-1:0];
    end else begin
      timer_irq_status_ff <= nxt_status;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign count_value = count_ff;
  assign timer_irq_status = timer_irq_status_ff;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_MATCH_A_STATUS: assert property (
    cmp_hit[0] && irq_en[0] |=> timer_irq_status_ff[FMC_ST_MATCH])
    else $error("Compare A match did not raise status one clock later");

  AST_MATCH_A_GATED: assert property (
    !timer_irq_status_ff[FMC_ST_MATCH] && !irq_en[0] |=> !timer_irq_status_ff[FMC_ST_MATCH])
    else $error("Compare A status rose while its enable was off");

  AST_MATCH_B_STATUS: assert property (
    count_ff == compare_ff[1] && match_action_control_ff[FMC_MC_STRIDE+FMC_MC_IRQ]
    |=> timer_irq_status_ff[FMC_ST_MATCH+1])
    else $error("Compare B match did not raise status");

  AST_MATCH_C_CLEAR: assert property (
    tick && count_ff == compare_ff[2] && match_action_control_ff[2*FMC_MC_STRIDE+FMC_MC_CLR]
    && !(wr_take && paddr == FMC_ADDR_COUNT) |=> count_ff == '0)
    else $error("Compare C clear action missing");

  AST_CLEAR_AT_PERIOD_END: assert property (
    cmp_hit[0] && clr_en[0] && !tick && !timer_control_ff[FMC_CTRL_CLR]
    && !(wr_take && paddr == FMC_ADDR_COUNT) |=> $stable(count_ff))
    else $error("Counter left matched value before its period ended");

  AST_HALT_ONE_CLOCK: assert property (
    cmp_hit[0] && halt_en[0] |=> !timer_control_ff[FMC_CTRL_RUN])
    else $error("Halt on compare A did not clear run enable");

  AST_PRESCALE_STEP: assert property (
    tick && !any_clear && !(wr_take && (paddr == FMC_ADDR_COUNT || paddr == FMC_ADDR_PCOUNT))
    |=> count_ff == $past(count_ff) + 1 && pcount_ff == '0)
    else $error("Counter did not advance by one at prescale tick");

  AST_STOPPED_HOLDS: assert property (
    !timer_control_ff[FMC_CTRL_RUN] && !timer_control_ff[FMC_CTRL_CLR]
    && !(wr_take && paddr == FMC_ADDR_COUNT) |=> $stable(count_ff))
    else $error("Counter moved while run enable was clear");

  AST_W1C_CAP_A: assert property (
    wr_take && paddr == FMC_ADDR_STATUS && pwdata[FMC_ST_CAP_A] && !cap_a_pulse
    |=> !timer_irq_status_ff[FMC_ST_CAP_A])
    else $error("Write of one did not clear capture A status");

  AST_CAPTURE_A_VALUE: assert property (
    cap_a_pulse |=> captured_count_a == $past(count_ff))
    else $error("Capture A did not hold the count at the edge");

  AST_CAPTURE_B_IRQ: assert property (
    cap_b_pulse && capture_edge_control_ff[FMC_CC_STRIDE+FMC_CC_IRQ]
    |=> timer_irq_status_ff[FMC_ST_CAP_B])
    else $error("Capture B event did not raise status");

  COV_CLEAR_ON_MATCH: cover property (tick && |(cmp_hit & clr_en));
  COV_HALT_ON_MATCH: cover property (timer_control_ff[FMC_CTRL_RUN] && any_halt);
  COV_BOTH_EDGES: cover property (
    cap_a_pulse && capture_edge_control_ff[FMC_CC_RISE] &&
    capture_edge_control_ff[FMC_CC_FALL] ##[1:200] cap_a_pulse);
  COV_CAPTURE_B: cover property (cap_b_pulse);

endmodule

`default_nettype wire

// ### hw/fmc_pkg.sv
// Purpose: Shared constants for the fast timer match and capture block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Addresses are the full byte addresses seen on paddr
`default_nettype none

package fmc_pkg;

  // Register byte addresses
  localparam logic [31:0] FMC_ADDR_STATUS = 32'h4003_8000;
  localparam logic [31:0] FMC_ADDR_CTRL = 32'h4003_8004;
  localparam logic [31:0] FMC_ADDR_COUNT = 32'h4003_8008;
  localparam logic [31:0] FMC_ADDR_PLIMIT = 32'h4003_800C;
  localparam logic [31:0] FMC_ADDR_PCOUNT = 32'h4003_8010;
  localparam logic [31:0] FMC_ADDR_MCTRL = 32'h4003_8014;
  localparam logic [31:0] FMC_ADDR_CMP_A = 32'h4003_8018;
  localparam logic [31:0] FMC_ADDR_CMP_B = 32'h4003_801C;
  localparam logic [31:0] FMC_ADDR_CMP_C = 32'h4003_8020;
  localparam logic [31:0] FMC_ADDR_CCR = 32'h4003_8028;
  localparam logic [31:0] FMC_ADDR_CAP_A = 32'h4003_802C;
  localparam logic [31:0] FMC_ADDR_CAP_B = 32'h4003_8030;

  // Reset value shared by every register
  localparam logic [31:0] FMC_RST_WORD = 32'h0000_0000;

  // Geometry
  localparam int unsigned FMC_CNT_W = 32;
  localparam int unsigned FMC_PRESCALE_W = 16;
  localparam int unsigned FMC_NUM_CMP = 3;

  // Timer control fields
  localparam int unsigned FMC_CTRL_W = 2;
  localparam int unsigned FMC_CTRL_RUN = 0;
  localparam int unsigned FMC_CTRL_CLR = 1;

  // Match action control: three fields per compare register
  localparam int unsigned FMC_MCTRL_W = 9;
  localparam int unsigned FMC_MC_STRIDE = 3;
  localparam int unsigned FMC_MC_IRQ = 0;
  localparam int unsigned FMC_MC_CLR = 1;
  localparam int unsigned FMC_MC_HALT = 2;

  // Capture edge control: three fields per channel
  localparam int unsigned FMC_CCR_W = 6;
  localparam int unsigned FMC_CC_STRIDE = 3;
  localparam int unsigned FMC_CC_RISE = 0;
  localparam int unsigned FMC_CC_FALL = 1;
  localparam int unsigned FMC_CC_IRQ = 2;

  // Interrupt status layout
  localparam int unsigned FMC_ST_W = 6;
  localparam int unsigned FMC_ST_MATCH = 0;
  localparam int unsigned FMC_ST_CAP_A = 4;
  localparam int unsigned FMC_ST_CAP_B = 5;

endpackage

`default_nettype wire
